// ===== rss_reset_seq.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
// Overview of operation
// R1: PLL fuse programmed selects the 64 MHz PLL divided by four, a 16 MHz clock.
// R2: Fuse setter must put clock source select to 0001 with the PLL option.
// R3: Start-up fuses pick 1K or 16K clock counts plus 4.1 ms or 65 ms delay.
// R4: Reset pin resets only while its disable fuse reads 1; else general I/O.
// R5: A pin low longer than 500 ns resets the device.
// R6: During reset I/O registers take initial values; fetch restarts at address zero.
// R7: Power-on threshold reached starts the delay counter; core held until time-out.
// R8: Supply falling below power-on level reasserts reset at once.
// R9: Pin rising starts the delay timer; core released after time-out.
// R10: Watchdog expiry while enabled gives an internal reset pulse one cycle long.
// R11: Falling edge of the watchdog pulse starts the time-out count.
// R12: Brown-out enabled and supply low asserts brown-out reset immediately.
// R13: Brown-out recovery releases after the same delay as power-on.
// R14: Brown-out valid only if low lasts over 2 us; shorter dips ignored.
// R15: Wake from power-down uses only the clock-count part of start-up.
// R16: Watchdog flag, bit 3, set by watchdog reset; cleared by power-on or zero write.
// R17: Brown-out flag, bit 2, set by brown-out; cleared by power-on or zero write.
// R18: External flag, bit 1, set by pin reset; cleared by power-on or zero write.
// R19: Power-on flag, bit 0, set by power-on; cleared only by writing zero.
// R20: Status bits 7 to 4 read as zero.
// R21: Software should read and clear the status early after start-up.
// R22: Core reset is the OR of all sources and the running delay timer.
module rss_reset_seq
  import rss_pkg::*;
#(
  parameter int unsigned TOUT_SHORT = TOUT_SHORT_CYC,  // Short real-time delay, cycles
  parameter int unsigned TOUT_LONG  = TOUT_LONG_CYC,   // Long real-time delay, cycles
  parameter int unsigned CK_LONG    = CK_LONG_CYC      // Long clock-count start-up
)
(
  input  wire logic              clk,                       // 10 MHz system clock
  input  wire logic              nrst,                      // Synchronous reset, active low
  input  wire logic              reset_pin_in,              // Level on the reset pin
  input  wire logic              supply_below_por,          // Power-on detector, high = low supply
  input  wire logic              supply_below_bod,          // Brown-out detector, high = low
  input  wire logic              wdt_enable,                // Watchdog enabled
  input  wire logic              wdt_expire,                // Watchdog period expired
  input  wire logic              wake_request,              // Wake from power-down, pulse
  input  wire logic              pll_sysclk_select_fuse,    // 0 = programmed
  input  wire logic [3:0]        clock_source_select_fuses, // Clock source code
  input  wire logic [1:0]        startup_time_fuses,        // Start-up time code
  input  wire logic              reset_pin_disable_fuse,    // 1 = pin is reset input
  input  wire logic              brownout_enable_fuse,      // 0 = programmed
  input  wire logic              brownout_level_fuse,       // Trigger level select
  input  wire logic [ADDR_W-1:0] reg_addr,                  // Register address
  input  wire logic [7:0]        reg_wdata,                 // Write data
  input  wire logic              reg_wr,                    // Write strobe
  input  wire logic              reg_rd,                    // Read strobe
  output logic      [7:0]        reg_rdata,                 // Read data, cycle after strobe
  output logic                   core_rst,                  // Core reset, active high
  output logic                   io_init,                   // Load I/O initial values
  output logic                   core_hold,                 // Core stalled during wake
  output logic                   pc_load,                   // Load fetch address, pulse
  output logic      [PC_W-1:0]   boot_pc,                   // Fetch address after reset
  output logic                   wdt_rst_pulse,             // Internal watchdog reset pulse
  output logic                   sysclk_pll_sel,            // PLL drives the system clock
  output logic      [2:0]        sysclk_div,                // Divide ratio of the source
  output logic                   clk_cfg_err,               // PLL chosen with wrong select
  output logic                   pin_gpio_in                // Pin level when used as I/O
);

  typedef enum logic [2:0] {RSS_HOLD, RSS_RT, RSS_CK, RSS_RUN, RSS_WAKE} rss_state_e;

  // Parameters wider than the counter cannot be served
  if (TOUT_LONG >= (1 << CNT_W) || TOUT_SHORT >= (1 << CNT_W) || CK_LONG >= (1 << CNT_W))
  begin : g_chk
    $error("Delay parameter exceeds counter width");
  end

  // Real-time part of the reset delay
  function automatic logic [CNT_W-1:0] rt_cycles(input logic [1:0] sut);
    unique case (sut)
      SUT_SHORT: rt_cycles = CNT_W'(TOUT_SHORT);
      SUT_LONG:  rt_cycles = CNT_W'(TOUT_LONG);
      default:   rt_cycles = '0;
    endcase
  endfunction

  // Clock-count part of the start-up time
  function automatic logic [CNT_W-1:0] ck_cycles(input logic [1:0] sut);
    ck_cycles = (sut == SUT_SLOW_CK) ? CNT_W'(CK_LONG) : CNT_W'(CK_SHORT_CYC);
  endfunction

  rss_tmr_if tmr ();

  rss_delay_timer u_timer (
    .clk  (clk),
    .nrst (nrst),
    .t    (tmr.tmr)
  );

  // Synchronisers: bit 0 pin, bit 1 power-on, bit 2 brown-out
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;

  // A change is accepted only when the second and third stages agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_r <= 3'h1;
      sync2_r <= 3'h1;
      sync3_r <= 3'h1;
      filt_r  <= 3'h1;
    end
    else
    begin
      sync1_r <= {supply_below_bod, supply_below_por, reset_pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 3; i++)
      begin
        if (sync2_r[i] == sync3_r[i])
        begin
          filt_r[i] <= sync3_r[i];
        end
      end
    end
  end

  wire pin_level = filt_r[0];
  wire por_level = filt_r[1];
  wire bod_level = filt_r[2];

  // External reset qualifier: the pin must stay low for the minimum width
  logic [7:0] ext_cnt_r;
  logic       ext_act_r;
  wire        pin_is_reset = reset_pin_disable_fuse;  // R4

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ext_cnt_r <= '0;
      ext_act_r <= 1'b0;
    end
    else if (!pin_is_reset || pin_level)
    begin
      ext_cnt_r <= '0;  // R9
      ext_act_r <= 1'b0;
    end
    else if (ext_cnt_r >= 8'(EXT_MIN_CYC - 1))
    begin
      ext_act_r <= 1'b1;  // R5
    end
    else
    begin
      ext_cnt_r <= ext_cnt_r + 8'h01;
    end
  end

  // Brown-out qualifier: dips shorter than the minimum are filtered away
  logic [7:0] bod_cnt_r;
  logic       bod_act_r;
  wire        bod_on = (brownout_enable_fuse == FUSE_PROG);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      bod_cnt_r <= '0;
      bod_act_r <= 1'b0;
    end
    else if (!bod_on || !bod_level)
    begin
      bod_cnt_r <= '0;  // R13
      bod_act_r <= 1'b0;
    end
    else if (bod_cnt_r >= 8'(BOD_MIN_CYC))
    begin
      bod_act_r <= 1'b1;  // R12 R14
    end
    else
    begin
      bod_cnt_r <= bod_cnt_r + 8'h01;
    end
  end

  // Watchdog pulse: one cycle on the rising edge of the expiry
  logic wdt_exp_d_r;
  logic wdt_pulse_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wdt_exp_d_r <= 1'b0;
      wdt_pulse_r <= 1'b0;
    end
    else
    begin
      wdt_exp_d_r <= wdt_expire;
      wdt_pulse_r <= wdt_expire && !wdt_exp_d_r && wdt_enable;  // R10
    end
  end

  wire src_any = por_level || ext_act_r || bod_act_r || wdt_pulse_r;  // R22

  // Release sequencer; a stale expiry in the load cycle is ignored
  rss_state_e       state_r;
  logic             load_r;
  logic [CNT_W-1:0] len_r;
  wire              tmr_done = tmr.done && !load_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r <= RSS_HOLD;
      load_r  <= 1'b0;
      len_r   <= '0;
    end
    else
    begin
      load_r <= 1'b0;
      if (src_any)
      begin
        state_r <= RSS_HOLD;  // R8 R12
      end
      else
      begin
        unique case (state_r)
          RSS_HOLD:
          begin
            // Sources just dropped: power-on, pin rise, brown-out end or watchdog pulse end
            load_r <= 1'b1;  // R7 R9 R11 R13
            if (rt_cycles(startup_time_fuses) != '0)
            begin
              len_r   <= rt_cycles(startup_time_fuses);  // R3
              state_r <= RSS_RT;
            end
            else
            begin
              len_r   <= ck_cycles(startup_time_fuses);
              state_r <= RSS_CK;
            end
          end
          RSS_RT:
          begin
            if (tmr_done)
            begin
              load_r  <= 1'b1;
              len_r   <= ck_cycles(startup_time_fuses);  // R3
              state_r <= RSS_CK;
            end
          end
          RSS_CK:
          begin
            if (tmr_done)
            begin
              state_r <= RSS_RUN;
            end
          end
          RSS_RUN:
          begin
            if (wake_request)
            begin
              load_r  <= 1'b1;
              len_r   <= ck_cycles(startup_time_fuses);  // R15
              state_r <= RSS_WAKE;
            end
          end
          RSS_WAKE:
          begin
            if (tmr_done)
            begin
              state_r <= RSS_RUN;
            end
          end
        endcase
      end
    end
  end

  assign tmr.load = load_r;
  assign tmr.len  = len_r;

  // Core reset and boot outputs
  logic core_rst_r;
  logic io_init_r;
  logic core_hold_r;
  logic pc_load_r;
  logic core_rst_nxt;

  assign core_rst_nxt = src_any || (state_r == RSS_HOLD) || (state_r == RSS_RT)
                        || (state_r == RSS_CK);  // R22

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      core_rst_r  <= 1'b1;
      io_init_r   <= 1'b1;
      core_hold_r <= 1'b0;
      pc_load_r   <= 1'b0;
    end
    else
    begin
      core_rst_r  <= core_rst_nxt;
      io_init_r   <= core_rst_nxt;  // R6
      core_hold_r <= !src_any && (state_r == RSS_WAKE);
      pc_load_r   <= core_rst_r && !core_rst_nxt;  // R6
    end
  end

  // Clock source selection follows the fuses
  logic       pll_sel_r;
  logic [2:0] div_r;
  logic       cfg_err_r;
  logic       gpio_r;
  wire        pll_fuse_on = (pll_sysclk_select_fuse == FUSE_PROG);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pll_sel_r <= 1'b0;
      div_r     <= NO_DIV;
      cfg_err_r <= 1'b0;
      gpio_r    <= 1'b0;
    end
    else
    begin
      pll_sel_r <= pll_fuse_on;  // R1
      div_r     <= pll_fuse_on ? PLL_DIV : NO_DIV;  // R1
      cfg_err_r <= pll_fuse_on && (clock_source_select_fuses != CKSEL_PLL);  // R2
      gpio_r    <= pin_is_reset ? 1'b0 : pin_level;  // R4
    end
  end

  // Reset cause flags; a setting event wins over a software clear
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;

  always_comb
  begin
    flags_nxt = flags_r;
    if (reg_wr && reg_addr == REG_STATUS)
    begin
      flags_nxt = flags_r & reg_wdata[3:0];  // R16 R17 R18 R19
    end
    if (por_level)
    begin
      flags_nxt[FLAG_POR] = 1'b1;  // R19
      flags_nxt[FLAG_EXT] = 1'b0;  // R18
      flags_nxt[FLAG_BOD] = 1'b0;  // R17
      flags_nxt[FLAG_WDT] = 1'b0;  // R16
    end
    else
    begin
      if (ext_act_r)
      begin
        flags_nxt[FLAG_EXT] = 1'b1;  // R18
      end
      if (bod_act_r)
      begin
        flags_nxt[FLAG_BOD] = 1'b1;  // R17
      end
      if (wdt_pulse_r)
      begin
        flags_nxt[FLAG_WDT] = 1'b1;  // R16
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      flags_r <= FLAGS_RESET;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // Read port: data valid only in the cycle after the strobe
  logic [7:0] rdata_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_r <= 8'h00;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_STATUS: rdata_r <= {4'h0, flags_r};  // R20
        REG_CONFIG: rdata_r <= {pin_level, brownout_level_fuse, bod_on, pin_is_reset,
                                startup_time_fuses, cfg_err_r, pll_sel_r};
        default:    rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata      = rdata_r;
  assign core_rst       = core_rst_r;
  assign io_init        = io_init_r;
  assign core_hold      = core_hold_r;
  assign pc_load        = pc_load_r;
  assign boot_pc        = BOOT_ADDR;
  assign wdt_rst_pulse  = wdt_pulse_r;
  assign sysclk_pll_sel = pll_sel_r;
  assign sysclk_div     = div_r;
  assign clk_cfg_err    = cfg_err_r;
  assign pin_gpio_in    = gpio_r;

endmodule

// ===== rss_pkg.sv
package rss_pkg;

  // Clock and rounding of times to cycles
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned EXT_MIN_LOW_NS  = 500;
  localparam int unsigned EXT_MIN_CYC     = (EXT_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOD_MIN_LOW_NS  = 2000;
  localparam int unsigned BOD_MIN_CYC     = (BOD_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real         TOUT_SHORT_MS   = 4.1;
  localparam real         TOUT_LONG_MS    = 65.0;
  localparam int unsigned TOUT_SHORT_CYC  = $rtoi(TOUT_SHORT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int unsigned TOUT_LONG_CYC   = $rtoi(TOUT_LONG_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int unsigned CK_SHORT_CYC    = 1024;
  localparam int unsigned CK_LONG_CYC     = 16384;

  // Delay counter width
  localparam int unsigned CNT_W           = 20;

  // PLL system clock option
  localparam int unsigned PLL_FREQ_MHZ    = 64;
  localparam int unsigned SYSCLK_MHZ      = 16;
  localparam logic [2:0]  PLL_DIV         = 3'(PLL_FREQ_MHZ / SYSCLK_MHZ);
  localparam logic [2:0]  NO_DIV          = 3'h1;
  localparam logic [3:0]  CKSEL_PLL       = 4'h1;
  localparam logic        FUSE_PROG       = 1'b0;

  // Start-up time fuse codes
  localparam logic [1:0]  SUT_NO_DELAY    = 2'h0;
  localparam logic [1:0]  SUT_SHORT       = 2'h1;
  localparam logic [1:0]  SUT_LONG        = 2'h2;
  localparam logic [1:0]  SUT_SLOW_CK     = 2'h3;

  // Register map
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  REG_STATUS      = 8'h00;
  localparam logic [7:0]  REG_CONFIG      = 8'h01;
  localparam logic [3:0]  FLAGS_RESET     = 4'h0;
  localparam int unsigned FLAG_POR        = 0;
  localparam int unsigned FLAG_EXT        = 1;
  localparam int unsigned FLAG_BOD        = 2;
  localparam int unsigned FLAG_WDT        = 3;

  // Boot fetch address
  localparam int unsigned PC_W            = 10;
  localparam logic [9:0]  BOOT_ADDR       = 10'h000;

endpackage

// ===== rss_tmr_if.sv
`timescale 1ns/1ps
interface rss_tmr_if;
  import rss_pkg::*;
  logic             load;
  logic [CNT_W-1:0] len;
  logic             done;
  modport ctl (output load, output len, input done);
  modport tmr (input load, input len, output done);
endinterface

// ===== rss_delay_timer.sv
`timescale 1ns/1ps
module rss_delay_timer
  import rss_pkg::*;
(
  input  wire logic clk,   // System clock
  input  wire logic nrst,  // Synchronous reset, active low
  rss_tmr_if.tmr    t      // Load and expiry handshake
);

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;
  logic             done_r;

  // Down counter; a load always restarts it, a zero length expires at once
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (t.load)
      begin
        cnt_r <= t.len;
        run_r <= 1'b1;
      end
      else if (run_r)
      begin
        if (cnt_r <= CNT_W'(1))
        begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      end
    end
  end

  assign t.done = done_r;

endmodule

// ===== rss_reset_seq_sva.sv
`timescale 1ns/1ps
module rss_reset_seq_sva
  import rss_pkg::*;
(
  input wire logic              clk,                       // System clock
  input wire logic              nrst,                      // Synchronous reset, active low
  input wire logic              supply_below_por,          // Power-on detector
  input wire logic              wdt_enable,                // Watchdog enabled
  input wire logic              wdt_expire,                // Watchdog period expired
  input wire logic              wake_request,              // Wake pulse
  input wire logic              pll_sysclk_select_fuse,    // 0 = programmed
  input wire logic [3:0]        clock_source_select_fuses, // Clock source code
  input wire logic [ADDR_W-1:0] reg_addr,                  // Register address
  input wire logic              reg_rd,                    // Read strobe
  input wire logic [7:0]        reg_rdata,                 // Read data
  input wire logic              core_rst,                  // Core reset
  input wire logic              io_init,                   // I/O initial load
  input wire logic              core_hold,                 // Wake stall
  input wire logic              pc_load,                   // Fetch address load
  input wire logic [PC_W-1:0]   boot_pc,                   // Fetch address
  input wire logic              wdt_rst_pulse,             // Watchdog reset pulse
  input wire logic              sysclk_pll_sel,            // PLL clock chosen
  input wire logic [2:0]        sysclk_div,                // Clock divide ratio
  input wire logic              clk_cfg_err                // Bad PLL select code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Watchdog pulse: one cycle, then the core is held for the nine cycles after it
  sequence s_wdt_pulse;
    wdt_rst_pulse ##1 (!wdt_rst_pulse && core_rst);
  endsequence
  sequence s_held;
    core_rst [*8];
  endsequence

  property p_wdt_pulse;
    $rose(wdt_expire) && wdt_enable |=> s_wdt_pulse ##1 s_held;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse wrong");
  property p_wdt_off;
    $rose(wdt_expire) && !wdt_enable |=> !wdt_rst_pulse;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("pulse with watchdog off");
  property p_io_init;
    io_init == core_rst;
  endproperty
  a_io_init: assert property (p_io_init) else $error("io init not with reset");
  property p_boot;
    boot_pc == BOOT_ADDR;
  endproperty
  a_boot: assert property (p_boot) else $error("boot address not zero");
  property p_pc_load;
    $fell(core_rst) |-> pc_load ##1 !pc_load;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("fetch load pulse wrong");
  property p_por;
    supply_below_por |-> ##[0:6] core_rst;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset late");
  property p_cfg_err;
    !pll_sysclk_select_fuse && clock_source_select_fuses != CKSEL_PLL |=> clk_cfg_err;
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("bad select not flagged");
  property p_pll_sel;
    pll_sysclk_select_fuse == FUSE_PROG |=> sysclk_pll_sel && sysclk_div == PLL_DIV;
  endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("PLL clock not chosen");
  property p_reserved;
    reg_rd && reg_addr == REG_STATUS |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  property p_wake;
    wake_request && !core_rst && !core_hold |-> ##2 (core_hold && !core_rst);
  endproperty
  a_wake: assert property (p_wake) else $error("wake stall missing");
endmodule

bind rss_reset_seq rss_reset_seq_sva u_sva (
  .clk(clk), .nrst(nrst), .supply_below_por(supply_below_por),
  .wdt_enable(wdt_enable), .wdt_expire(wdt_expire), .wake_request(wake_request),
  .pll_sysclk_select_fuse(pll_sysclk_select_fuse),
  .clock_source_select_fuses(clock_source_select_fuses),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_rst(core_rst),
  .io_init(io_init), .core_hold(core_hold), .pc_load(pc_load), .boot_pc(boot_pc),
  .wdt_rst_pulse(wdt_rst_pulse), .sysclk_pll_sel(sysclk_pll_sel),
  .sysclk_div(sysclk_div), .clk_cfg_err(clk_cfg_err)
);

// ===== rss_far_model.sv
`timescale 1ns/1ps
module rss_far_model
(
  input  wire logic clk,     // System clock
  output logic      pin,     // Reset pin, pulled up when idle
  output logic      por_low, // Supply under power-on level
  output logic      bod_low, // Supply under brown-out level
  output logic      wdt_exp  // Watchdog period expired
);
  // Supply starts low, as at power-up
  initial
  begin
    pin = 1'h1;
    por_low = 1'h1;
    bod_low = 1'h0;
    wdt_exp = 1'h0;
  end

  // Pin pulled low for n cycles, then back to the pull-up level
  task automatic pin_low(input int n);
    @(posedge clk) pin <= 1'h0;
    repeat (n) @(posedge clk);
    pin <= 1'h1;
  endtask

  // Supply dips; short brown-out dips must be filtered by the device
  task automatic bod_dip(input int n);
    @(posedge clk) bod_low <= 1'h1;
    repeat (n) @(posedge clk);
    bod_low <= 1'h0;
  endtask

  task automatic por_dip(input int n);
    @(posedge clk) por_low <= 1'h1;
    repeat (n) @(posedge clk);
    por_low <= 1'h0;
  endtask

  // Expiry seen as a rising edge, so one cycle is enough
  task automatic wdt_fire();
    @(posedge clk) wdt_exp <= 1'h1;
    @(posedge clk) wdt_exp <= 1'h0;
  endtask
endmodule

// ===== rss_reset_seq_bench.sv
`timescale 1ns/1ps
module rss_reset_seq_bench;
  import rss_pkg::*;
  // Short real-time delays keep the run brief
  localparam int TS = 20;
  localparam int TL = 40;
  localparam int CL = 30;
  localparam int CK = 1024;
  logic            clk, nrst, wdt_enable, wake_request, pll_sysclk_select_fuse;
  logic            reset_pin_disable_fuse, brownout_enable_fuse, brownout_level_fuse;
  logic [3:0]      clock_source_select_fuses;
  logic [1:0]      startup_time_fuses;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata;
  logic            reg_wr, reg_rd, core_rst, io_init, core_hold, pc_load;
  logic            wdt_rst_pulse, sysclk_pll_sel, clk_cfg_err, pin_gpio_in;
  logic            reset_pin_in, supply_below_por, supply_below_bod, wdt_expire;
  logic [PC_W-1:0] boot_pc;
  logic [2:0]      sysclk_div;
  int              fail_count, checks_done;

  rss_reset_seq #(.TOUT_SHORT(TS), .TOUT_LONG(TL), .CK_LONG(CL)) DUT (
    .clk(clk), .nrst(nrst), .reset_pin_in(reset_pin_in),
    .supply_below_por(supply_below_por), .supply_below_bod(supply_below_bod),
    .wdt_enable(wdt_enable), .wdt_expire(wdt_expire), .wake_request(wake_request),
    .pll_sysclk_select_fuse(pll_sysclk_select_fuse),
    .clock_source_select_fuses(clock_source_select_fuses),
    .startup_time_fuses(startup_time_fuses), .reset_pin_disable_fuse(reset_pin_disable_fuse),
    .brownout_enable_fuse(brownout_enable_fuse), .brownout_level_fuse(brownout_level_fuse),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_rst(core_rst), .io_init(io_init), .core_hold(core_hold),
    .pc_load(pc_load), .boot_pc(boot_pc), .wdt_rst_pulse(wdt_rst_pulse),
    .sysclk_pll_sel(sysclk_pll_sel), .sysclk_div(sysclk_div), .clk_cfg_err(clk_cfg_err),
    .pin_gpio_in(pin_gpio_in)
  );
  rss_far_model far (.clk(clk), .pin(reset_pin_in), .por_low(supply_below_por),
    .bod_low(supply_below_bod), .wdt_exp(wdt_expire));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Sample just after an edge so registered outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk) reg_wr <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk) reg_rd <= 1'h0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask

  // Cycles from source removal to release; window allows synchroniser slack
  task automatic wait_rel(input int lo);
    int n;
    n = 4;
    step(4);
    while (core_rst !== 1'h0 && n < lo + 40)
    begin
      step(1);
      n++;
    end
    check("release_time", n >= lo && n <= lo + 14, 1'h1);
    check("pc_load", pc_load, 1'h1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Run takes about 6500 cycles; cut off well beyond that
  initial
  begin
    #3000000;
    fail_count++;
    $display("watchdog timeout");
    report_and_stop();
  end

  initial
  begin
    int n;
    nrst = 1'h0;
    wdt_enable = 1'h0;
    wake_request = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    pll_sysclk_select_fuse = FUSE_PROG;
    brownout_enable_fuse = FUSE_PROG;
    reset_pin_disable_fuse = 1'h1;
    brownout_level_fuse = 1'h1;
    clock_source_select_fuses = CKSEL_PLL;
    startup_time_fuses = SUT_NO_DELAY;
    {reg_addr, reg_wdata} = 16'h0000;
    fail_count = 0;
    checks_done = 0;
    n = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    far.por_dip(2);
    wait_rel(CK);
    rd_exp(REG_STATUS, 8'h01);
    wr(REG_STATUS, 8'h00);
    rd_exp(REG_STATUS, 8'h00);
    rd_exp(8'h7f, 8'h00);
    // Clock selection
    check("div", {sysclk_pll_sel, clk_cfg_err, sysclk_div}, {2'h2, PLL_DIV});
    @(posedge clk) clock_source_select_fuses <= 4'h2;
    step(2);
    check("cfg_err", clk_cfg_err, 1'h1);
    @(posedge clk) pll_sysclk_select_fuse <= 1'h1;
    clock_source_select_fuses <= CKSEL_PLL;
    step(2);
    check("div", {sysclk_pll_sel, sysclk_div}, {1'h0, NO_DIV});
    @(posedge clk) pll_sysclk_select_fuse <= FUSE_PROG;
    // External pin, then a pulse too short to count
    startup_time_fuses <= SUT_SHORT;
    far.pin_low(10);
    wait_rel(TS + CK);
    rd_exp(REG_STATUS, 8'h02);
    wr(REG_STATUS, 8'h00);
    far.pin_low(3);
    step(10);
    check("core_rst", core_rst, 1'h0);
    // Pin used as plain input
    @(posedge clk) reset_pin_disable_fuse <= 1'h0;
    fork
      far.pin_low(12);
      begin
        step(10);
        check("gpio", pin_gpio_in, 1'h0);
      end
    join
    step(8);
    check("gpio_rst", {pin_gpio_in, core_rst}, 2'h2);
    rd_exp(REG_STATUS, 8'h00);
    @(posedge clk) reset_pin_disable_fuse <= 1'h1;
    // Watchdog enabled, then disabled
    startup_time_fuses <= SUT_LONG;
    wdt_enable <= 1'h1;
    far.wdt_fire();
    wait_rel(TL + CK);
    rd_exp(REG_STATUS, 8'h08);
    @(posedge clk) wdt_enable <= 1'h0;
    startup_time_fuses <= SUT_NO_DELAY;
    far.wdt_fire();
    step(10);
    check("core_rst", core_rst, 1'h0);
    // Power-on clears the other flags
    far.pin_low(10);
    wait_rel(CK);
    rd_exp(REG_STATUS, 8'h0a);
    far.por_dip(5);
    wait_rel(CK);
    rd_exp(REG_STATUS, 8'h01);
    wr(REG_STATUS, 8'h0e);
    rd_exp(REG_STATUS, 8'h00);
    // Brown-out: short dip, real dip, then disabled
    @(posedge clk) startup_time_fuses <= SUT_SLOW_CK;
    far.bod_dip(10);
    step(10);
    check("core_rst", core_rst, 1'h0);
    far.bod_dip(30);
    wait_rel(CL);
    rd_exp(REG_STATUS, 8'h04);
    wr(REG_STATUS, 8'h00);
    @(posedge clk) brownout_enable_fuse <= 1'h1;
    brownout_level_fuse <= 1'h0;
    far.bod_dip(30);
    step(10);
    check("core_rst", core_rst, 1'h0);
    rd_exp(REG_STATUS, 8'h00);
    rd_exp(REG_CONFIG, 8'h9d);
    // Wake uses the clock count only, not the real-time part
    @(posedge clk) startup_time_fuses <= SUT_SHORT;
    wake_request <= 1'h1;
    @(posedge clk) wake_request <= 1'h0;
    step(3);
    while (core_hold === 1'h1 && n < 2000)
    begin
      step(1);
      n++;
    end
    check("wake_len", n >= CK - 12 && n <= CK + 4, 1'h1);
    check("core_rst", core_rst, 1'h0);
    report_and_stop();
  end
endmodule
